// [sire_buf2.sv]
// Small FIFO between the control byte receiver and the pending word
`timescale 1ns/1ps
`default_nettype none
module sire_buf2 #(parameter int W = 8, parameter int DEPTH = 2) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r, rd_r;
   logic [AW:0] cnt_r;
   logic push, pop;

   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_r[rd_r];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + AW'(1);
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + AW'(1);
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + (AW+1)'(1);
         end else if (pop && !push) begin
            cnt_r <= cnt_r - (AW+1)'(1);
         end
      end
   end
endmodule : sire_buf2
`default_nettype wire

// [sire_far_model.sv]
// Far-side model: host serial transmitter and infrared transceiver
`timescale 1ns/1ps
`default_nettype none
module sire_far_model #(
   parameter int MIN_W = 4
) (
   // Clock
   input wire logic clk,
   // Lines toward the block
   output logic uart_tx_in,
   output logic ir_rx_pulse_n
);
   // ----------------------------------------------------------------
   // Line drivers
   // ----------------------------------------------------------------
   initial begin
      uart_tx_in = 1'b1;
      ir_rx_pulse_n = 1'b1;
   end

   // Start bit, eight data bits LSB first, no parity, one stop bit
   task automatic send_byte(input logic [7:0] b, input int bit_cyc);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         uart_tx_in <= fr[i];
         repeat (bit_cyc - 1) @(posedge clk);
      end
   endtask : send_byte

   // A real transceiver never sends a pulse below the minimum width
   task automatic ir_pulse(input int w);
      int n;
      n = (w < MIN_W) ? MIN_W : w;
      @(posedge clk);
      ir_rx_pulse_n <= 1'b0;
      repeat (n) @(posedge clk);
      ir_rx_pulse_n <= 1'b1;
   endtask : ir_pulse
endmodule : sire_far_model
`default_nettype wire

// [sire_pkg.sv]
// Constants and carrier types of the infrared pulse encoder/decoder
package sire_pkg;
   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned SIRE_CLK_HZ = 32'h02FAF080;
   localparam longint unsigned SIRE_PS_PER_S = 64'h000000E8D4A51000;
   localparam longint unsigned SIRE_SHORT_PULSE_PS = 64'h000000000018D378;
   localparam int SIRE_DATA_BITS = 32'h00000008;
   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [3:0] SIRE_OFS_CFG = 4'h0;
   localparam logic [3:0] SIRE_OFS_CTRL = 4'h4;
   localparam logic [3:0] SIRE_OFS_STAT = 4'h8;
   localparam logic [3:0] SIRE_OFS_BYTE = 4'hC;
   // ----------------------------------------------------------------
   // Control word layout, bits 6..0 of the programming byte
   // ----------------------------------------------------------------
   typedef struct packed {
      logic back;
      logic front;
      logic pulse_long;
      logic [3:0] rate;
   } sire_cfg_t;
   localparam sire_cfg_t SIRE_CFG_RST = '{1'b0, 1'b0, 1'b1, 4'h6};
   typedef enum logic [3:0] {
      SIRE_RX_IDLE = 4'b0001,
      SIRE_RX_START = 4'b0010,
      SIRE_RX_DATA = 4'b0100,
      SIRE_RX_STOP = 4'b1000
   } sire_rx_st_t;
   // Bit rate in bit/s for each rate code; unused codes fall to 9600
   function automatic int unsigned sire_rate_hz(input logic [3:0] code);
      case (code)
         4'h0: return 32'h0001C200;
         4'h1: return 32'h0000E100;
         4'h2: return 32'h00009600;
         4'h3: return 32'h00004B00;
         4'h4: return 32'h00003840;
         4'h5: return 32'h00003200;
         4'h7: return 32'h00001C20;
         4'h8: return 32'h000012C0;
         4'h9: return 32'h00000E10;
         default: return 32'h00002580;
      endcase
   endfunction : sire_rate_hz
endpackage : sire_pkg

// [sire_timer.sv]
// Reloadable down counter used for bit and pulse timing
`timescale 1ns/1ps
`default_nettype none
module sire_timer #(parameter int CW = 16) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Control
   input wire logic load,
   input wire logic [CW-1:0] load_val,
   // State
   output logic [CW-1:0] cnt,
   output logic done
);
   logic [CW-1:0] cnt_r;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_r <= '0;
      end else if (load) begin
         cnt_r <= load_val;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - CW'(1);
      end
   end

   assign cnt = cnt_r;
   assign done = (cnt_r == CW'(1));
endmodule : sire_timer
`default_nettype wire

// [sire_top.sv]
// Serial infrared pulse encoder/decoder with Avalon-MM status registers
// What this block does
// - Drive infrared transmit output active high with shortened pulses.
// - Reset loads defaults into the state and control registers (buffer storage is not reset); it must be applied at start.
// - Reset selects 9600 bit/s and the fixed 1.627 us pulse width.
// - Transceiver shutdown output follows the reset level.
// - Oscillator is stopped while reset is active.
// - Data mode shortens each zero transmit bit onto the infrared output.
// - Data mode stretches each received pulse that starts outside a stretch to one full bit time.
// - Programming mode takes transmit characters as control words.
// - Control word waits pending until programming mode is left.
// - Two general outputs are active-low levels from programmed bits.
// - Receive indicator goes low while infrared receive is active.
// - Byte bits 3..0 rate, 4 pulse select, 5 and 6 outputs, 7 ignored.
// - Rate codes 0 to 9 select 115.2 down to 3.6 kbit/s.
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module sire_top import sire_pkg::*; #(
   parameter int unsigned CLK_HZ = SIRE_CLK_HZ,
   parameter int CW = 16,
   parameter int BUF_DEPTH = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Serial port side
   input wire logic uart_tx_in,
   output logic uart_rx_out,
   input wire logic program_mode_sel,
   // Transceiver side
   output logic ir_tx_pulse,
   input wire logic ir_rx_pulse_n,
   output logic xcvr_shutdown_n,
   output logic osc_enable,
   // Indicators and general outputs
   output logic rx_indicator_n,
   output logic user_out_front_n,
   output logic user_out_back_n,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   // ----------------------------------------------------------------
   // Timing derived from the clock
   // ----------------------------------------------------------------
   localparam logic [CW-1:0] SHORT_CYC = CW'((longint'(SIRE_SHORT_PULSE_PS)
      * longint'(CLK_HZ) + SIRE_PS_PER_S - 64'h1) / SIRE_PS_PER_S);
   logic [CW-1:0] bit_tab [16];
   for (genvar g = 0; g < 16; g++) begin : g_rate
      assign bit_tab[g] = CW'(CLK_HZ / sire_rate_hz(4'(g)));
   end

   sire_cfg_t cfg_r;
   logic [CW-1:0] bit_cyc, pulse_cyc;
   logic [CW+1:0] bit_x3;
   assign bit_cyc = bit_tab[cfg_r.rate];
   assign bit_x3 = (CW+2)'({bit_cyc, 1'b0}) + (CW+2)'(bit_cyc);
   // Pulse is 1.627 us or 3/16 of the bit, whichever is selected
   assign pulse_cyc = cfg_r.pulse_long ? SHORT_CYC : CW'(bit_x3[CW+1:4]);

   // ----------------------------------------------------------------
   // Reset-driven pins and general outputs
   // ----------------------------------------------------------------
   assign xcvr_shutdown_n = reset_n;
   assign osc_enable = reset_n;
   assign user_out_front_n = ~cfg_r.front;
   assign user_out_back_n = ~cfg_r.back;

   // ----------------------------------------------------------------
   // Timers
   // ----------------------------------------------------------------
   logic eb_load, pt_load, st_load, ut_load;
   logic [CW-1:0] eb_cnt, pt_cnt, st_cnt, ut_cnt, ut_val;
   logic eb_done, ut_done;

   sire_timer #(.CW(CW)) u_bit_tmr (.clk(clk), .reset_n(reset_n),
      .load(eb_load), .load_val(bit_cyc), .cnt(eb_cnt), .done(eb_done));
   sire_timer #(.CW(CW)) u_pulse_tmr (.clk(clk), .reset_n(reset_n),
      .load(pt_load), .load_val(pulse_cyc), .cnt(pt_cnt), .done());
   sire_timer #(.CW(CW)) u_stretch_tmr (.clk(clk), .reset_n(reset_n),
      .load(st_load), .load_val(bit_cyc), .cnt(st_cnt), .done());
   sire_timer #(.CW(CW)) u_uart_tmr (.clk(clk), .reset_n(reset_n),
      .load(ut_load), .load_val(ut_val), .cnt(ut_cnt), .done(ut_done));

   // ----------------------------------------------------------------
   // Encoder
   // ----------------------------------------------------------------
   logic tx_prev_r, tx_fall, ir_tx_r;
   assign tx_fall = tx_prev_r && !uart_tx_in;
   // A start or zero bit begins with a falling edge; later zero bits are
   // found by sampling the line at each bit boundary
   assign eb_load = !program_mode_sel && !uart_tx_in
      && (tx_fall || eb_done);
   assign pt_load = eb_load;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_prev_r <= 1'b1;
         ir_tx_r <= 1'b0;
      end else begin
         tx_prev_r <= uart_tx_in;
         ir_tx_r <= pt_load || (pt_cnt > CW'(1));
      end
   end
   assign ir_tx_pulse = ir_tx_r;

   // ----------------------------------------------------------------
   // Decoder
   // ----------------------------------------------------------------
   logic irx_prev_r, uart_rx_r, rx_ind_r;
   // Edges during a stretch are ignored, so one pulse gives one bit
   assign st_load = !program_mode_sel && irx_prev_r && !ir_rx_pulse_n
      && (st_cnt == '0);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irx_prev_r <= 1'b1;
         uart_rx_r <= 1'b1;
         rx_ind_r <= 1'b1;
      end else begin
         irx_prev_r <= ir_rx_pulse_n;
         uart_rx_r <= !(st_load || (st_cnt > CW'(1)));
         rx_ind_r <= !(st_load || (st_cnt > CW'(1)));
      end
   end
   assign uart_rx_out = uart_rx_r;
   assign rx_indicator_n = rx_ind_r;

   // ----------------------------------------------------------------
   // Control byte receiver
   // ----------------------------------------------------------------
   sire_rx_st_t st_r;
   logic [7:0] sh_r, rxb_r;
   logic [2:0] nbit_r;
   logic rxb_valid_r, byte_done, ovr_r, buf_in_ready;

   always_comb begin
      ut_load = 1'b0;
      ut_val = bit_cyc;
      byte_done = 1'b0;
      unique case (st_r)
         SIRE_RX_IDLE: begin
            ut_load = program_mode_sel && tx_fall;
            ut_val = {1'b0, bit_cyc[CW-1:1]};
         end
         SIRE_RX_START: ut_load = ut_done && !uart_tx_in;
         SIRE_RX_DATA: ut_load = ut_done;
         SIRE_RX_STOP: byte_done = ut_done && uart_tx_in;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n || !program_mode_sel) begin
         st_r <= SIRE_RX_IDLE;
         nbit_r <= '0;
      end else begin
         unique case (st_r)
            SIRE_RX_IDLE: if (ut_load) st_r <= SIRE_RX_START;
            SIRE_RX_START: begin
               if (ut_done) begin
                  st_r <= uart_tx_in ? SIRE_RX_IDLE : SIRE_RX_DATA;
               end
               nbit_r <= '0;
            end
            SIRE_RX_DATA: begin
               if (ut_done) begin
                  nbit_r <= nbit_r + 3'h1;
                  if (nbit_r == 3'(SIRE_DATA_BITS - 1)) begin
                     st_r <= SIRE_RX_STOP;
                  end
               end
            end
            SIRE_RX_STOP: if (ut_done) st_r <= SIRE_RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sh_r <= '0;
      end else if (st_r == SIRE_RX_DATA && ut_done) begin
         sh_r <= {uart_tx_in, sh_r[7:1]};
      end
   end

   // A finished byte waits here while the buffer is full; a second one
   // arriving meanwhile overwrites it and is flagged as overrun
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rxb_r <= '0;
         rxb_valid_r <= 1'b0;
      end else if (byte_done) begin
         rxb_r <= sh_r;
         rxb_valid_r <= 1'b1;
      end else if (buf_in_ready) begin
         rxb_valid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Buffer, pending word and live configuration
   // ----------------------------------------------------------------
   logic buf_out_valid, hold_r, pend_valid_r, mode_prev_r, apply;
   logic [7:0] buf_out_data, pend_r;

   sire_buf2 #(.W(8), .DEPTH(BUF_DEPTH)) u_buf (.clk(clk),
      .reset_n(reset_n), .in_valid(rxb_valid_r), .in_ready(buf_in_ready),
      .in_data(rxb_r), .out_valid(buf_out_valid), .out_ready(!hold_r),
      .out_data(buf_out_data));

   assign apply = mode_prev_r && !program_mode_sel && pend_valid_r;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pend_r <= '0;
         pend_valid_r <= 1'b0;
         mode_prev_r <= 1'b0;
      end else begin
         mode_prev_r <= program_mode_sel;
         if (buf_out_valid && !hold_r) begin
            pend_r <= buf_out_data;
            pend_valid_r <= 1'b1;
         end else if (apply) begin
            pend_valid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cfg_r <= SIRE_CFG_RST;
      end else if (apply) begin
         cfg_r <= sire_cfg_t'(pend_r[6:0]);
      end
   end

   // ----------------------------------------------------------------
   // Avalon-MM registers
   // ----------------------------------------------------------------
   logic ack_r, wr_ok;
   logic [31:0] rdata_r;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign avs_readdata = rdata_r;
   assign wr_ok = avs_write && ack_r && avs_byteenable[0];

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         ack_r <= (avs_read || avs_write) && !ack_r;
         if (avs_read && !ack_r) begin
            case (avs_address)
               SIRE_OFS_CFG: rdata_r <= {23'h0, pend_valid_r, 1'b0, cfg_r};
               SIRE_OFS_CTRL: rdata_r <= {31'h0, hold_r};
               SIRE_OFS_STAT: rdata_r <= {28'h0, !buf_in_ready,
                  buf_out_valid, st_r != SIRE_RX_IDLE, ovr_r};
               SIRE_OFS_BYTE: rdata_r <= {24'h0, pend_r};
               default: rdata_r <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         hold_r <= 1'b0;
      end else if (wr_ok && avs_address == SIRE_OFS_CTRL) begin
         hold_r <= avs_writedata[0];
      end
   end

   // Overrun set wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ovr_r <= 1'b0;
      end else if (byte_done && rxb_valid_r && !buf_in_ready) begin
         ovr_r <= 1'b1;
      end else if (wr_ok && avs_address == SIRE_OFS_STAT
         && avs_writedata[0]) begin
         ovr_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [CW-1:0] hi_cnt_r, lo_cnt_r;
   always_ff @(posedge clk) begin
      hi_cnt_r <= ir_tx_r ? hi_cnt_r + CW'(1) : '0;
      lo_cnt_r <= uart_rx_r ? '0 : lo_cnt_r + CW'(1);
   end

   reset_defaults_a: assert property ($rose(reset_n) |->
      cfg_r == SIRE_CFG_RST && !pend_valid_r && !ir_tx_r)
      else $error("defaults not set after reset");
   shutdown_pins_a: assert property (@(posedge clk) disable iff (1'b0)
      !reset_n |-> !xcvr_shutdown_n && !osc_enable)
      else $error("shutdown or oscillator active in reset");
   short_pulse_a: assert property ($fell(ir_tx_r) && cfg_r.pulse_long
      && $stable(cfg_r) |-> hi_cnt_r == SHORT_CYC)
      else $error("short pulse width wrong");
   zero_bit_only_a: assert property ($rose(ir_tx_r) |->
      $past(!uart_tx_in) && $past(!program_mode_sel))
      else $error("pulse without zero bit");
   prog_no_tx_a: assert property (program_mode_sel
      && $past(program_mode_sel) |-> !$rose(ir_tx_r))
      else $error("pulse sent in programming mode");
   rx_stretch_a: assert property ($rose(uart_rx_r) && $stable(cfg_r)
      |-> $past(lo_cnt_r) + CW'(1) == bit_cyc)
      else $error("stretched bit length wrong");
   rx_indicator_a: assert property (!rx_indicator_n |-> !uart_rx_out)
      else $error("indicator without receive");
   apply_on_exit_a: assert property ($changed(cfg_r) |->
      $past(mode_prev_r) && !$past(program_mode_sel))
      else $error("config changed outside mode exit");
   apply_fields_a: assert property (apply |=>
      cfg_r.rate == $past(pend_r[3:0])
      && cfg_r.pulse_long == $past(pend_r[4])
      && user_out_front_n == !$past(pend_r[5])
      && user_out_back_n == !$past(pend_r[6]))
      else $error("control byte fields misplaced");

   tx_pulse_c: cover property ($fell(ir_tx_r));
   rx_stretch_c: cover property ($rose(uart_rx_r));
   apply_c: cover property (apply);
   overrun_c: cover property ($rose(ovr_r));
endmodule : sire_top
`default_nettype wire

// [tb_sir_infrared_pulse_endec.sv]
// Self-checking bench for the infrared pulse encoder/decoder
`timescale 1ns/1ps
`default_nettype none
module tb_sir_infrared_pulse_endec import sire_pkg::*; ();
   // ----------------------------------------------------------------
   // Setup
   // ----------------------------------------------------------------
   // Slow clock parameter keeps the long rate codes affordable
   localparam int unsigned CLK = 32'h001E8480;
   localparam int MIN_W = 4;
   localparam int LONG_W = (longint'(CLK) * 64'h65B + 64'h3B9AC9FF)
      / 64'h3B9ACA00;
   typedef struct packed {
      logic [7:0] b;
      logic [31:0] hz;
   } sire_row_t;
   sire_row_t rows [10] = '{'{8'h10, 32'h1C200}, '{8'hA1, 32'hE100},
      '{8'h52, 32'h9600}, '{8'h33, 32'h4B00}, '{8'h04, 32'h3840},
      '{8'hF5, 32'h3200}, '{8'h16, 32'h2580}, '{8'h27, 32'h1C20},
      '{8'h48, 32'h12C0}, '{8'h39, 32'hE10}};
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic program_mode_sel = 1'b0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic uart_tx_in, uart_rx_out, ir_tx_pulse, ir_rx_pulse_n;
   logic xcvr_shutdown_n, osc_enable, rx_indicator_n;
   logic user_out_front_n, user_out_back_n;
   logic [6:0] cur_cfg = 7'h16;
   logic tx_q = 1'b0;
   int cur_bit = 0;
   int miscompares = 0;
   int n_checks = 0;
   int tx_hi = 0;
   int tx_rise = 0;
   int rx_lo = 0;
   int ind_lo = 0;

   always #10 clk = ~clk;

   // Cycle counters sample on the falling edge, where outputs are settled
   always @(negedge clk) begin
      if (ir_tx_pulse === 1'b1) tx_hi++;
      if (ir_tx_pulse === 1'b1 && tx_q !== 1'b1) tx_rise++;
      tx_q = ir_tx_pulse;
      if (uart_rx_out === 1'b0) rx_lo++;
      if (rx_indicator_n === 1'b0) ind_lo++;
   end

   sire_far_model #(.MIN_W(MIN_W)) sire_far_model_inst (.clk(clk),
      .uart_tx_in(uart_tx_in), .ir_rx_pulse_n(ir_rx_pulse_n));

   sire_top #(.CLK_HZ(CLK)) sire_top_inst (.clk(clk), .reset_n(reset_n),
      .uart_tx_in(uart_tx_in), .uart_rx_out(uart_rx_out),
      .program_mode_sel(program_mode_sel), .ir_tx_pulse(ir_tx_pulse),
      .ir_rx_pulse_n(ir_rx_pulse_n), .xcvr_shutdown_n(xcvr_shutdown_n),
      .osc_enable(osc_enable), .rx_indicator_n(rx_indicator_n),
      .user_out_front_n(user_out_front_n),
      .user_out_back_n(user_out_back_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // Request held until waitrequest is seen low at a rising edge
   task automatic avs_xfer(input logic wr, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
      int i;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= ~wr;
      avs_write <= wr;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (i == 20) begin
         miscompares++;
         finish_test();
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : avs_xfer

   task automatic rd(input logic [3:0] a, output logic [31:0] q);
      avs_xfer(1'b0, a, 32'h0, 4'hF, q);
   endtask : rd

   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
      logic [31:0] q;
      avs_xfer(1'b1, a, d, be, q);
   endtask : wr

   task automatic do_reset();
      logic [31:0] q;
      @(posedge clk);
      reset_n <= 1'b0;
      program_mode_sel <= 1'b0;
      cyc(2);
      @(negedge clk);
      chk("shutdown in reset", 32'h0, xcvr_shutdown_n);
      chk("oscillator in reset", 32'h0, osc_enable);
      chk("ir tx in reset", 32'h0, ir_tx_pulse);
      @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk("shutdown released", 32'h1, xcvr_shutdown_n);
      chk("oscillator released", 32'h1, osc_enable);
      rd(SIRE_OFS_CFG, q);
      chk("cfg default", 32'h16, q[6:0]);
      rd(SIRE_OFS_CTRL, q);
      chk("ctrl default", 32'h0, q[0]);
      rd(SIRE_OFS_STAT, q);
      chk("stat default", 32'h0, q[3:0]);
      chk("front default", 32'h1, user_out_front_n);
      chk("back default", 32'h1, user_out_back_n);
      cur_cfg = 7'h16;
      cur_bit = CLK / 32'h2580;
      $display("test reset done");
   endtask : do_reset

   task automatic program_byte(input logic [7:0] b);
      logic [31:0] q;
      int r0;
      @(posedge clk);
      program_mode_sel <= 1'b1;
      r0 = tx_rise;
      sire_far_model_inst.send_byte(b, cur_bit);
      cyc(cur_bit);
      chk("no tx while programming", r0, tx_rise);
      rd(SIRE_OFS_BYTE, q);
      chk("pending byte", b[6:0], q[6:0]);
      rd(SIRE_OFS_CFG, q);
      chk("cfg held", cur_cfg, q[6:0]);
      chk("pending flag", 32'h1, q[8]);
      @(posedge clk);
      program_mode_sel <= 1'b0;
      cyc(3);
      rd(SIRE_OFS_CFG, q);
      chk("cfg applied", b[6:0], q[6:0]);
      chk("pending cleared", 32'h0, q[8]);
      cur_cfg = b[6:0];
   endtask : program_byte

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      cyc(32'h186A0);
      miscompares++;
      finish_test();
   end

   initial begin
      logic [31:0] q;
      int nb, pw, h0, r0, l0, i0;
      do_reset();
      // Rate codes 0 to 9, both pulse forms, both general outputs
      foreach (rows[k]) begin
         nb = CLK / rows[k].hz;
         program_byte(rows[k].b);
         cur_bit = nb;
         pw = rows[k].b[4] ? LONG_W : (3 * nb) / 16;
         chk("front out", !rows[k].b[5], user_out_front_n);
         chk("back out", !rows[k].b[6], user_out_back_n);
         h0 = tx_hi;
         r0 = tx_rise;
         sire_far_model_inst.send_byte(8'h55, nb);
         cyc(nb);
         chk("tx pulse count", r0 + 5, tx_rise);
         chk("tx pulse width", h0 + 5 * pw, tx_hi);
         l0 = rx_lo;
         i0 = ind_lo;
         sire_far_model_inst.ir_pulse(MIN_W);
         cyc(2);
         sire_far_model_inst.ir_pulse(MIN_W);
         cyc(nb + 4);
         chk("rx stretch", l0 + nb, rx_lo);
         chk("rx indicator", i0 + nb, ind_lo);
         $display("test rate row %0d done", k);
      end
      do_reset();
      // Drain stalled: buffer fills, then the receiver overruns
      wr(SIRE_OFS_CTRL, 32'h1, 4'hF);
      rd(SIRE_OFS_CTRL, q);
      chk("ctrl hold", 32'h1, q[0]);
      @(posedge clk);
      program_mode_sel <= 1'b1;
      repeat (4) sire_far_model_inst.send_byte(8'h36, cur_bit);
      cyc(cur_bit);
      rd(SIRE_OFS_STAT, q);
      chk("buffer full", 32'hD, q[3:0] & 4'hD);
      wr(SIRE_OFS_STAT, 32'h1, 4'hF);
      rd(SIRE_OFS_STAT, q);
      chk("overrun cleared", 32'h0, q[0]);
      wr(SIRE_OFS_CTRL, 32'h0, 4'hF);
      cyc(8);
      rd(SIRE_OFS_STAT, q);
      chk("buffer empty", 32'h0, q[3:0]);
      @(posedge clk);
      program_mode_sel <= 1'b0;
      cyc(3);
      rd(SIRE_OFS_CFG, q);
      chk("cfg after drain", 32'h36, q[6:0]);
      chk("front after drain", 32'h0, user_out_front_n);
      $display("test buffer done");
      // Unmapped, read-only and masked writes leave state alone
      wr(4'h2, 32'hFFFFFFFF, 4'hF);
      rd(4'h2, q);
      chk("unmapped read", 32'h0, q);
      wr(SIRE_OFS_CFG, 32'h0, 4'hF);
      rd(SIRE_OFS_CFG, q);
      chk("cfg read only", 32'h36, q[6:0]);
      wr(SIRE_OFS_CTRL, 32'h1, 4'h0);
      rd(SIRE_OFS_CTRL, q);
      chk("masked write", 32'h0, q[0]);
      $display("test bus refusals done");
      finish_test();
   end
endmodule : tb_sir_infrared_pulse_endec
`default_nettype wire
